/* an_regs.sv */
// negotiation control, status and page registers behind an AHB-Lite slave
//
// Overview of operation
// - command bit 0 resets negotiation machines, self-clears
// - command bit 4 restarts tx, only in negotiation
// - bit 8 announces next page, else null pages
// - next page flag travels in bit D15
// - page received flag set, cleared on read
// - status bit 2 shows negotiation complete
// - fault sent flag sticky, D13 carries fault
// - status bit 4 shows receive machine idle
// - status bit 5 ability tied to one
// - link status bit clears on read
// - status bit 7 shows partner ability
// - status bit 8 shows fec negotiated
// - status bit 9 shows sequencer failure
// - bits 17:12 link ready per technology, one-hot except KX reads zero
// - user base low word fills page bits 15:0 except ack bit 14 and echo bits 9:5
// - machine always drives page bit 49
// - override field 21:16 replaces technology bits
// - override field 25:24 replaces fec bits
// - override field 30:28 replaces pause bits
// - overrides act only with config bit 5
// - user base high word fills bits 47:16
// - user next low word fills next page
// - config bit 1 selects user base pages
// - config bit 2 selects user next pages
// - user next high maps to bits 47:16
`timescale 1ns/1ps
module an_regs
  import an_regs_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // negotiation engine side
  input wire engine_s engine,
  input wire adv_s adv_default,
  input wire logic [47:0] machine_page,
  output logic an_reset_pulse,
  output logic tx_restart_pulse,
  output logic np_announce_pulse,
  output logic an_enable,
  output logic force_nonce,
  output adv_s adv,
  output logic [49:0] tx_base_page,
  output logic [49:0] tx_next_page
);

  // technology to link ready code, one-hot except zero for KX
  function automatic logic [5:0] ready_code(input tech_e t);
    logic [5:0] c;
    c = READY_KX;
    unique case (t)
      TECH_KX: c = READY_KX;
      TECH_KX4: c = READY_KX4;
      TECH_KR: c = READY_KR;
      TECH_KR4: c = READY_KR4;
      TECH_CR4: c = READY_CR4;
      TECH_CR10: c = READY_CR10;
      default: c = READY_KX;
    endcase
    return c;
  endfunction

  // address phase capture
  logic dphase_q;            // data phase of a write pending
  logic [29:0] widx_q;       // word index of that write
  logic [31:0] cfg_q;        // configuration word
  logic [31:0] base_lo_q;    // user base low and overrides
  logic [31:0] base_hi_q;    // user base high
  logic [31:0] next_lo_q;    // user next low
  logic [31:0] next_hi_q;    // user next high
  logic np_pending_q;        // fresh next page loaded
  logic page_rx_q;           // sticky page received
  logic fault_q;             // sticky fault sent
  logic link_q;              // link status, cleared on read
  logic [31:0] hrdata_q;     // registered read data
  logic [31:0] status_w;     // assembled status word
  logic take;                // address phase accepted
  logic rd_status;           // status read accepted
  logic wr_cmd;              // command write in data phase
  logic [5:0] ovr_tech;      // technology override field

  // accept any valid transfer when the bus is ready
  assign take = hsel && htrans[1] && hready;
  assign rd_status = take && !hwrite && (haddr[31:2] == IDX_STATUS);
  assign wr_cmd = dphase_q && (widx_q == IDX_COMMAND);

  // always ready, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign ovr_tech = base_lo_q[OVR_TECH_LSB +: 6];

  // remember write address for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dphase_q <= 1'b0;
      widx_q <= 30'h00000000;
    end else begin
      dphase_q <= take && hwrite;
      widx_q <= haddr[31:2];
    end
  end

  // software-written words
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q <= CONFIG_RESET;
      base_lo_q <= WORD_RESET;
      base_hi_q <= WORD_RESET;
      next_lo_q <= WORD_RESET;
      next_hi_q <= WORD_RESET;
    end else if (dphase_q) begin
      unique case (widx_q)
        IDX_CONFIG: cfg_q <= hwdata & CONFIG_MASK;
        IDX_BASE_LOW: base_lo_q <= hwdata & BASE_LOW_MASK;
        IDX_BASE_HIGH: base_hi_q <= hwdata;
        IDX_NEXT_LOW: next_lo_q <= {16'h0000, hwdata[15:0]};
        IDX_NEXT_HIGH: next_hi_q <= hwdata;
        default: ; // command, status and unmapped words store nothing
      endcase
    end
  end

  // one-clock command pulses, command word reads back zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      an_reset_pulse <= 1'b0;
      tx_restart_pulse <= 1'b0;
      np_announce_pulse <= 1'b0;
    end else begin
      an_reset_pulse <= wr_cmd && hwdata[CMD_RESET];
      // restart only counts while tx is negotiating
      tx_restart_pulse <= wr_cmd && hwdata[CMD_RESTART]
        && engine.tx_in_an;
      np_announce_pulse <= wr_cmd && hwdata[CMD_NEXT_PAGE];
    end
  end

  // next page held loaded until the engine takes it or a reset pulse, set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      np_pending_q <= 1'b0;
    end else if (wr_cmd && hwdata[CMD_NEXT_PAGE]) begin
      np_pending_q <= 1'b1;
    end else if (engine.np_taken || an_reset_pulse) begin
      np_pending_q <= 1'b0;
    end
  end

  // sticky status flags, set wins over clear on read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      page_rx_q <= 1'b0;
      fault_q <= 1'b0;
      link_q <= 1'b0;
    end else begin
      page_rx_q <= engine.page_rx || (page_rx_q && !rd_status);
      fault_q <= engine.fault_sent || (fault_q && !rd_status);
      link_q <= engine.link_up || (link_q && !rd_status);
    end
  end

  // status word assembly
  always_comb begin
    status_w = 32'h00000000;
    status_w[ST_PAGE_RX] = page_rx_q;
    status_w[ST_COMPLETE] = engine.complete;
    status_w[ST_FAULT_SENT] = fault_q;
    status_w[ST_RX_QUIET] = engine.rx_quiet;
    status_w[ST_ABILITY] = 1'b1;
    status_w[ST_LINK] = link_q;
    status_w[ST_LP_ABLE] = engine.lp_able;
    status_w[ST_FEC] = engine.fec_on;
    status_w[ST_SEQ_FAIL] = engine.seq_fail;
    // ready code only while receive idle and link up
    if (engine.rx_quiet && engine.link_up) begin
      status_w[ST_READY_LSB +: 6] = ready_code(engine.resolved);
    end
  end

  // read data captured at the address phase edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= WORD_RESET;
    end else if (take && !hwrite) begin
      unique case (haddr[31:2])
        IDX_CONFIG: hrdata_q <= cfg_q;
        IDX_STATUS: hrdata_q <= status_w;
        IDX_BASE_LOW: hrdata_q <= base_lo_q;
        IDX_BASE_HIGH: hrdata_q <= base_hi_q;
        IDX_NEXT_LOW: hrdata_q <= next_lo_q;
        IDX_NEXT_HIGH: hrdata_q <= next_hi_q;
        default: hrdata_q <= WORD_RESET; // command and unmapped
      endcase
    end
  end

  // configuration levels and advertised fields
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      an_enable <= CONFIG_RESET[CFG_ENABLE];
      force_nonce <= 1'b0;
      adv <= '0;
    end else begin
      an_enable <= cfg_q[CFG_ENABLE];
      force_nonce <= cfg_q[CFG_FORCE_NONCE];
      if (cfg_q[CFG_OVERRIDE]) begin
        adv.tech <= ovr_tech[5:0];
        adv.fec <= base_lo_q[OVR_FEC_LSB +: 2];
        adv.pause <= base_lo_q[OVR_PAUSE_LSB +: 3];
      end else begin
        adv <= adv_default;
      end
    end
  end

  // base page: user words or machine page with patches
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_base_page <= '0;
    end else begin
      if (cfg_q[CFG_USER_BASE]) begin
        tx_base_page[15:0] <= base_lo_q[15:0];
        tx_base_page[47:16] <= base_hi_q;
        tx_base_page[PG_ACK] <= engine.ack;
        tx_base_page[PG_ECHO_LSB +: 5] <= engine.echo;
      end else begin
        tx_base_page[47:0] <= machine_page;
        tx_base_page[PG_NP] <= np_pending_q;
        tx_base_page[PG_RF] <= cfg_q[CFG_LOCAL_FAULT];
        tx_base_page[PG_ACK] <= engine.ack;
        if (cfg_q[CFG_OVERRIDE]) begin
          tx_base_page[PG_TECH_LSB +: 6] <= ovr_tech[5:0];
          tx_base_page[PG_FEC_LSB +: 2] <=
            base_lo_q[OVR_FEC_LSB +: 2];
          tx_base_page[PG_PAUSE_LSB +: 3] <=
            base_lo_q[OVR_PAUSE_LSB +: 3];
        end
      end
      tx_base_page[48] <= 1'b0;
      tx_base_page[PG_PRBS] <= engine.prbs;
    end
  end

  // next page: user words when loaded, else null message
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_next_page <= '0;
    end else begin
      if (cfg_q[CFG_USER_NEXT] && np_pending_q) begin
        tx_next_page[15:0] <= next_lo_q[15:0];
        tx_next_page[47:16] <= next_hi_q;
        tx_next_page[PG_ACK] <= engine.ack;
      end else begin
        tx_next_page[47:16] <= 32'h00000000;
        tx_next_page[PG_NP] <= 1'b0;
        tx_next_page[PG_ACK] <= engine.ack;
        tx_next_page[PG_MP] <= 1'b1;
        tx_next_page[PG_SECOND_ACKNOWLEDGE_FLAG] <= engine.second_acknowledge_flag;
        tx_next_page[PG_TOGGLE] <= engine.toggle;
        tx_next_page[10:0] <= NULL_MESSAGE;
      end
      tx_next_page[48] <= 1'b0;
      tx_next_page[PG_PRBS] <= engine.prbs;
    end
  end

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_reset_cmd;
    wr_cmd && hwdata[CMD_RESET] |=> an_reset_pulse;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd)
    else $error("reset command gave no pulse");

  property p_pulse_cause;
    an_reset_pulse |-> $past(wr_cmd) && $past(hwdata[CMD_RESET]);
  endproperty
  a_pulse_cause: assert property (p_pulse_cause)
    else $error("reset pulse without a command write");

  property p_restart_gate;
    wr_cmd && hwdata[CMD_RESTART]
      |=> tx_restart_pulse == $past(engine.tx_in_an);
  endproperty
  a_restart_gate: assert property (p_restart_gate)
    else $error("restart pulse not gated by tx state");

  property p_null_page;
    !(cfg_q[CFG_USER_NEXT] && np_pending_q)
      |=> tx_next_page[10:0] == NULL_MESSAGE && !tx_next_page[PG_NP];
  endproperty
  a_null_page: assert property (p_null_page)
    else $error("null page not sent without loaded next page");

  property p_page_rx_clear;
    rd_status && !engine.page_rx |=> !page_rx_q;
  endproperty
  a_page_rx_clear: assert property (p_page_rx_clear)
    else $error("page received flag not cleared by read");

  property p_fault_clear;
    rd_status && !engine.fault_sent |=> !fault_q;
  endproperty
  a_fault_clear: assert property (p_fault_clear)
    else $error("fault sent flag not cleared by read");

  property p_link_clear;
    rd_status && !engine.link_up |=> !link_q;
  endproperty
  a_link_clear: assert property (p_link_clear)
    else $error("link status flag not cleared by read");

  property p_ability;
    rd_status |=> hrdata[ST_ABILITY];
  endproperty
  a_ability: assert property (p_ability)
    else $error("ability bit did not read one");

  property p_ready_onehot;
    $onehot0(status_w[ST_READY_LSB +: 6]);
  endproperty
  a_ready_onehot: assert property (p_ready_onehot)
    else $error("link ready field not one-hot");

  property p_no_override;
    !cfg_q[CFG_OVERRIDE] |=> adv == $past(adv_default);
  endproperty
  a_no_override: assert property (p_no_override)
    else $error("override applied without enable");

  property p_prbs;
    ##1 tx_base_page[PG_PRBS] == $past(engine.prbs);
  endproperty
  a_prbs: assert property (p_prbs)
    else $error("page bit 49 not from machine");

endmodule

/* an_regs_pkg.sv */
// constants and carrier types for the negotiation register bank
package an_regs_pkg;

  // word indices of the registers (byte address is four times the index)
  localparam logic [29:0] IDX_CONFIG = 30'h000004C0;
  localparam logic [29:0] IDX_COMMAND = 30'h000004C1;
  localparam logic [29:0] IDX_STATUS = 30'h000004C2;
  localparam logic [29:0] IDX_BASE_LOW = 30'h000004C3;
  localparam logic [29:0] IDX_BASE_HIGH = 30'h000004C4;
  localparam logic [29:0] IDX_NEXT_LOW = 30'h000004C5;
  localparam logic [29:0] IDX_NEXT_HIGH = 30'h000004C6;

  // reset values
  localparam logic [31:0] CONFIG_RESET = 32'h00000001;
  localparam logic [31:0] WORD_RESET = 32'h00000000;

  // configuration bits
  localparam int CFG_ENABLE = 0;
  localparam int CFG_USER_BASE = 1;
  localparam int CFG_USER_NEXT = 2;
  localparam int CFG_LOCAL_FAULT = 3;
  localparam int CFG_FORCE_NONCE = 4;
  localparam int CFG_OVERRIDE = 5;
  localparam logic [31:0] CONFIG_MASK = 32'h0000003F;

  // command bits
  localparam int CMD_RESET = 0;
  localparam int CMD_RESTART = 4;
  localparam int CMD_NEXT_PAGE = 8;

  // status bits
  localparam int ST_PAGE_RX = 1;
  localparam int ST_COMPLETE = 2;
  localparam int ST_FAULT_SENT = 3;
  localparam int ST_RX_QUIET = 4;
  localparam int ST_ABILITY = 5;
  localparam int ST_LINK = 6;
  localparam int ST_LP_ABLE = 7;
  localparam int ST_FEC = 8;
  localparam int ST_SEQ_FAIL = 9;
  localparam int ST_READY_LSB = 12;

  // override fields of the base page low word
  localparam int OVR_TECH_LSB = 16;
  localparam int OVR_FEC_LSB = 24;
  localparam int OVR_PAUSE_LSB = 28;
  localparam logic [31:0] BASE_LOW_MASK = 32'h733FFFFF;

  // link codeword bit positions
  localparam int PG_NP = 15;
  localparam int PG_ACK = 14;
  localparam int PG_RF = 13;
  localparam int PG_MP = 13;
  localparam int PG_SECOND_ACKNOWLEDGE_FLAG = 12;
  localparam int PG_TOGGLE = 11;
  localparam int PG_PAUSE_LSB = 10;
  localparam int PG_ECHO_LSB = 5;
  localparam int PG_TECH_LSB = 21;
  localparam int PG_FEC_LSB = 46;
  localparam int PG_PRBS = 49;
  localparam logic [10:0] NULL_MESSAGE = 11'h001;

  // link ready codes, one-hot except KX at zero
  localparam logic [5:0] READY_KX = 6'h00;
  localparam logic [5:0] READY_KX4 = 6'h01;
  localparam logic [5:0] READY_KR = 6'h04;
  localparam logic [5:0] READY_KR4 = 6'h08;
  localparam logic [5:0] READY_CR4 = 6'h10;
  localparam logic [5:0] READY_CR10 = 6'h20;

  // resolved technology
  typedef enum logic [2:0] {
    TECH_KX, TECH_KX4, TECH_KR, TECH_KR4, TECH_CR4, TECH_CR10
  } tech_e;

  // state and events reported by the negotiation engine
  typedef struct packed {
    logic page_rx;        // pulse: page received
    logic fault_sent;     // pulse: fault sent to partner
    logic complete;       // level: negotiation done
    logic rx_quiet;       // level: receive machine idle
    logic link_up;        // level: link status
    logic lp_able;        // level: partner can negotiate
    logic fec_on;         // level: fec negotiated
    logic seq_fail;       // level: sequencer failure
    tech_e resolved;      // resolved technology
    logic ack;            // acknowledge bit from machine
    logic second_acknowledge_flag;           // second acknowledge for null pages
    logic toggle;         // toggle bit for null pages
    logic prbs;           // pseudo-random page bit
    logic [4:0] echo;     // echoed nonce from machine
    logic tx_in_an;       // tx machine in negotiation state
    logic np_taken;       // pulse: next page consumed
  } engine_s;

  // advertised fields
  typedef struct packed {
    logic [5:0] tech;
    logic [1:0] fec;
    logic [2:0] pause;
  } adv_s;

endpackage

/* engine_model.sv */
// behavioural negotiation engine that faces the register bank
`timescale 1ns/1ps
module engine_model
  import an_regs_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // levels and pulses chosen by the bench
  input wire engine_s levels,
  // commands from the register bank
  input wire logic np_announce_pulse,
  input wire logic an_reset_pulse,
  // engine view seen by the bank
  output engine_s engine
);
  logic [2:0] wait_q; // cycles left until the next page is taken

  // a page is consumed some cycles after it is announced
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_q <= 3'h0;
    end else if (an_reset_pulse) begin
      wait_q <= 3'h0; // reset drops the pending page
    end else if (np_announce_pulse) begin
      wait_q <= 3'h6;
    end else if (wait_q != 3'h0) begin
      wait_q <= wait_q - 3'h1;
    end
  end

  // bench levels with the taken pulse merged in
  always_comb begin
    engine = levels;
    engine.np_taken = (wait_q == 3'h1);
  end
endmodule

/* backplane_autoneg_ctrl_status_regs_bench.sv */
// self-checking bench for the negotiation register bank
`timescale 1ns/1ps
module backplane_autoneg_ctrl_status_regs_bench;
  import an_regs_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  engine_s levels, engine;
  adv_s adv_default, adv;
  logic [47:0] machine_page;
  logic an_reset_pulse, tx_restart_pulse, np_announce_pulse;
  logic an_enable, force_nonce;
  logic [49:0] tx_base_page, tx_next_page;
  int n_mismatch = 0; // mismatches seen
  int checked = 0; // comparisons made
  int cycles = 0; // clock cycles run
  logic [31:0] v; // read data

  an_regs i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .engine(engine),
    .adv_default(adv_default), .machine_page(machine_page),
    .an_reset_pulse(an_reset_pulse), .tx_restart_pulse(tx_restart_pulse),
    .np_announce_pulse(np_announce_pulse), .an_enable(an_enable),
    .force_nonce(force_nonce), .adv(adv), .tx_base_page(tx_base_page),
    .tx_next_page(tx_next_page));

  engine_model i_engine (.hclk(hclk), .hresetn(hresetn), .levels(levels),
    .np_announce_pulse(np_announce_pulse),
    .an_reset_pulse(an_reset_pulse), .engine(engine));

  // free running bus clock
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // verdict and end of run
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      close_out();
    end
  end

  // compare one value
  task automatic check(input string name, input logic [63:0] seen,
    input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one single ahb-lite transfer, entered just after a rising edge
  task automatic bus(input logic [29:0] idx, input logic wr,
    input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {idx, 2'b00};
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [29:0] idx, input logic [31:0] d);
    logic [31:0] x;
    bus(idx, 1'b1, d, x);
  endtask

  task automatic rd(input logic [29:0] idx, output logic [31:0] d);
    bus(idx, 1'b0, 32'h00000000, d);
  endtask

  // values after reset and an unmapped word
  task automatic t_reset();
    rd(IDX_CONFIG, v);
    check("config", v, 64'h1);
    check("enable out", an_enable, 64'h1);
    check("nonce out", force_nonce, 64'h0);
    check("response", hresp, 64'h0);
    rd(IDX_COMMAND, v);
    check("command", v, 64'h0);
    rd(30'h000004C7, v);
    check("unmapped", v, 64'h0);
    rd(IDX_STATUS, v);
    check("status idle", v, 64'h20);
  endtask

  // self-clearing command pulses
  task automatic t_commands();
    levels.tx_in_an <= 1'b1;
    wr(IDX_COMMAND, 32'h00000111);
    #1;
    check("reset pulse", an_reset_pulse, 64'h1);
    check("restart pulse", tx_restart_pulse, 64'h1);
    check("announce pulse", np_announce_pulse, 64'h1);
    @(posedge hclk);
    #1;
    check("reset gone", an_reset_pulse, 64'h0);
    check("restart gone", tx_restart_pulse, 64'h0);
    @(posedge hclk);
    rd(IDX_COMMAND, v);
    check("command clear", v, 64'h0);
    levels.tx_in_an <= 1'b0;
    wr(IDX_COMMAND, 32'h00000010);
    #1;
    check("restart refused", tx_restart_pulse, 64'h0);
  endtask

  // status flags, clear on read and link ready codes
  task automatic t_status();
    logic [5:0] codes [6] = '{6'h00, 6'h01, 6'h04, 6'h08, 6'h10, 6'h20};
    @(posedge hclk);
    levels.page_rx <= 1'b1;
    levels.fault_sent <= 1'b1;
    {levels.complete, levels.rx_quiet, levels.link_up} <= 3'h7;
    {levels.lp_able, levels.fec_on, levels.seq_fail} <= 3'h7;
    levels.resolved <= TECH_KR;
    @(posedge hclk);
    levels.page_rx <= 1'b0;
    levels.fault_sent <= 1'b0;
    repeat (3) @(posedge hclk);
    rd(IDX_STATUS, v);
    check("status set", v, 64'h43FE);
    levels.complete <= 1'b0;
    {levels.rx_quiet, levels.link_up, levels.lp_able} <= 3'h0;
    {levels.fec_on, levels.seq_fail} <= 2'h0;
    @(posedge hclk);
    rd(IDX_STATUS, v);
    check("status left", v, 64'h60);
    rd(IDX_STATUS, v);
    check("link cleared", v, 64'h20);
    {levels.rx_quiet, levels.link_up} <= 2'h3;
    for (int i = 0; i < 6; i++) begin
      levels.resolved <= tech_e'(i);
      @(posedge hclk);
      rd(IDX_STATUS, v);
      check("ready code", v[17:12], codes[i]);
    end
  endtask

  // override fields gated by config bit 5
  task automatic t_override();
    wr(IDX_BASE_LOW, 32'h532A0000);
    rd(IDX_BASE_LOW, v);
    check("base low", v, 64'h532A0000);
    wr(IDX_CONFIG, 32'h00000001);
    repeat (2) @(posedge hclk);
    check("adv default", adv, adv_default);
    wr(IDX_CONFIG, 32'h00000031);
    repeat (2) @(posedge hclk);
    check("nonce forced", force_nonce, 64'h1);
    check("adv tech", adv.tech, 64'h2A);
    check("adv fec", adv.fec, 64'h3);
    check("adv pause", adv.pause, 64'h5);
    check("page tech", tx_base_page[26:21], 64'h2A);
  endtask

  // machine and user built base pages
  task automatic t_base_page();
    wr(IDX_CONFIG, 32'h00000009);
    repeat (2) @(posedge hclk);
    check("machine", tx_base_page[45:16], machine_page[45:16]);
    check("fault bit", tx_base_page[13], 64'h1);
    levels.ack <= 1'b1;
    levels.echo <= 5'h15;
    levels.prbs <= 1'b1;
    wr(IDX_BASE_LOW, 32'h0000B3C7);
    wr(IDX_BASE_HIGH, 32'h2AAAAAAA);
    wr(IDX_CONFIG, 32'h00000003);
    repeat (2) @(posedge hclk);
    check("user low", tx_base_page[15:0], 64'hF2A7);
    check("user high", tx_base_page[45:16], 64'h2AAAAAAA);
    check("prbs one", tx_base_page[49], 64'h1);
    levels.prbs <= 1'b0;
    repeat (2) @(posedge hclk);
    check("prbs zero", tx_base_page[49], 64'h0);
  endtask

  // null pages and announced user next pages
  task automatic t_next_page();
    levels.second_acknowledge_flag <= 1'b0;
    levels.toggle <= 1'b1;
    wr(IDX_CONFIG, 32'h00000005);
    repeat (2) @(posedge hclk);
    check("null page", tx_next_page[15:0], 64'h6801);
    wr(IDX_NEXT_LOW, 32'h0000B800);
    wr(IDX_NEXT_HIGH, 32'hDEADBEEF);
    rd(IDX_NEXT_LOW, v);
    check("next low", v, 64'hB800);
    wr(IDX_COMMAND, 32'h00000100);
    @(posedge hclk);
    #1;
    check("next page", tx_next_page[15:0], 64'hF800);
    check("next high", tx_next_page[47:16], 64'hDEADBEEF);
    check("base np", tx_base_page[15], 64'h1);
    repeat (8) @(posedge hclk);
    check("null again", tx_next_page[15:0], 64'h6801);
    wr(IDX_CONFIG, 32'h00000001);
    wr(IDX_COMMAND, 32'h00000100);
    @(posedge hclk);
    #1;
    check("null forced", tx_next_page[15:0], 64'h6801);
  endtask

  // main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    levels = '0;
    adv_default = '{tech: 6'h01, fec: 2'h0, pause: 3'h0};
    machine_page = 48'h123456789ABC;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_commands();
    t_status();
    t_override();
    t_base_page();
    t_next_page();
    close_out();
  end
endmodule
